// *** design/dco_defines.vh ***
// Constants for the downconverter filter configuration and overrange block
`ifndef DCO_DEFINES_VH
`define DCO_DEFINES_VH
`define DCO_IDX_FILT_CFG  10'h210
`define DCO_IDX_THR_FIRST 10'h211
`define DCO_IDX_THR_SEC   10'h212
`define DCO_IDX_PIN_CFG   10'h213
`define DCO_IDX_PRESET    10'h214
`define DCO_IDX_SPIN      10'h297
`define DCO_IDX_MODE      10'h2B0
`define DCO_RST_FILT_CFG  8'h00
`define DCO_RST_THR_FIRST 8'hF2
`define DCO_RST_THR_SEC   8'hAB
`define DCO_RST_PIN_CFG   8'h07
`define DCO_RST_PRESET    8'h00
`define DCO_RST_MODE      8'h00
`define DCO_BIT_WIDE_BAND 3
`define DCO_BIT_HIGHPASS  2
`define DCO_BIT_FLIP      1
`define DCO_BIT_GAIN      0
`define DCO_BIT_PIN_EN    3
`define DCO_MODE_BYPASS   2'h0
`define DCO_MODE_REAL     2'h1
`define DCO_MODE_COMPLEX  2'h2
`define DCO_PERIOD_BASE   11'h008
`define DCO_SMP_MAX       12'h7FF
`define DCO_SMP_MIN       12'h800
`define DCO_SPIN_VALUE    8'h5A
`endif

// *** design/dco_top.v ***
// Downconverter filter configuration, overrange detection and output FIFO
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "dco_defines.vh"

module dco_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  reg [AW:0]      cnt_next;
  reg             nf_reg;
  reg             ov_reg;
  reg [WIDTH-1:0] od_reg;
  wire            push;
  wire            pop;

  assign push      = in_valid & nf_reg;
  // Output register refills whenever empty or being taken
  assign pop       = (cnt_reg != 0) & (~ov_reg | out_ready);
  assign in_ready  = nf_reg;
  assign out_valid = ov_reg;
  assign out_data  = od_reg;

  always @* begin
    cnt_next = cnt_reg;
    if (push & ~pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop & ~push)
      cnt_next = cnt_reg - 1'b1;
  end

  always @(posedge clk) begin
    if (push & ce)
      mem[wp_reg] <= in_data;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      nf_reg  <= 1'b1;
      ov_reg  <= 1'b0;
      od_reg  <= {WIDTH{1'b0}};
    end else if (ce) begin
      cnt_reg <= cnt_next;
      // Ready is taken from the next count so it is never a cycle late
      nf_reg  <= (cnt_next != DEPTH);
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
        od_reg <= mem[rp_reg];
        ov_reg <= 1'b1;
      end else if (out_ready) begin
        ov_reg <= 1'b0;
      end
    end
  end
endmodule // dco_fifo

module dco_top (
  input  wire        SYS_CLK,
  input  wire        RSTN,
  input  wire        CE,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  input  wire [11:0] SMP_A,
  input  wire [11:0] SMP_B,
  input  wire        SMP_VALID,
  output wire        SMP_READY,
  output wire [27:0] OUT_DATA,
  output wire        OUT_VALID,
  input  wire        OUT_READY,
  output wire        CHAN_A_OVER_FLAG_FIRST,
  output wire        CHAN_A_OVER_FLAG_SECOND,
  output wire        CHAN_B_OVER_FLAG_FIRST,
  output wire        CHAN_B_OVER_FLAG_SECOND,
  output wire        QUARTER_DECIM_WIDE_BAND_SEL,
  output wire        HALF_DECIM_HIGHPASS_SEL
);
  // Spin value is arbitrary
  parameter [7:0] SILICON_REVISION_ID_VALUE = `DCO_SPIN_VALUE;

  reg  [7:0]  filt_cfg_reg;
  reg  [7:0]  filt_cfg_next;
  reg  [7:0]  thr_first_reg;
  reg  [7:0]  thr_first_next;
  reg  [7:0]  thr_sec_reg;
  reg  [7:0]  thr_sec_next;
  reg  [7:0]  pin_cfg_reg;
  reg  [7:0]  pin_cfg_next;
  reg  [7:0]  preset_reg;
  reg  [7:0]  preset_next;
  reg  [7:0]  mode_reg;
  reg  [7:0]  mode_next;
  reg         wr_pend_reg;
  reg  [9:0]  wr_idx_reg;
  reg  [31:0] rdata_reg;
  reg  [7:0]  rdata_next;
  reg         wide_reg;
  reg         hpass_reg;
  reg         odd_reg;
  reg  [10:0] per_cnt_reg;
  reg         ready_reg;
  reg         resp_reg;
  reg  [11:0] out_a;
  reg  [11:0] out_b;
  wire [9:0]  idx;
  wire        addr_ok;
  wire        req;
  wire        take;
  wire [1:0]  mode;
  wire        flip_on;
  wire        gain_on;
  wire [10:0] per_len;
  wire        per_end;
  wire [11:0] mag_a;
  wire [11:0] mag_b;
  wire [11:0] lvl_first;
  wire [11:0] lvl_second;
  wire [3:0]  det;
  wire [3:0]  hit;
  wire [27:0] fifo_in;
  wire        fifo_rdy;
  wire [3:0]  pin_q;

  assign idx     = HADDR[11:2];
  assign addr_ok = (HADDR[31:12] == 20'h00000);
  assign req     = HSEL & HTRANS[1] & HREADY;

  // Write lands at the end of its data phase
  always @* begin
    filt_cfg_next  = filt_cfg_reg;
    thr_first_next = thr_first_reg;
    thr_sec_next   = thr_sec_reg;
    pin_cfg_next   = pin_cfg_reg;
    preset_next    = preset_reg;
    mode_next      = mode_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `DCO_IDX_FILT_CFG:  filt_cfg_next  = HWDATA[7:0];
        `DCO_IDX_THR_FIRST: thr_first_next = HWDATA[7:0];
        `DCO_IDX_THR_SEC:   thr_sec_next   = HWDATA[7:0];
        `DCO_IDX_PIN_CFG:   pin_cfg_next   = HWDATA[7:0];
        `DCO_IDX_PRESET:    preset_next    = HWDATA[7:0];
        `DCO_IDX_MODE:      mode_next      = HWDATA[7:0];
        default:            mode_next      = mode_reg;
      endcase
    end
  end

  // Reads see next values so a read right after a write is coherent
  always @* begin
    rdata_next = 8'h00;
    if (addr_ok) begin
      case (idx)
        `DCO_IDX_FILT_CFG:  rdata_next = filt_cfg_next;
        `DCO_IDX_THR_FIRST: rdata_next = thr_first_next;
        `DCO_IDX_THR_SEC:   rdata_next = thr_sec_next;
        `DCO_IDX_PIN_CFG:   rdata_next = pin_cfg_next;
        `DCO_IDX_PRESET:    rdata_next = preset_next;
        `DCO_IDX_SPIN:      rdata_next = SILICON_REVISION_ID_VALUE;
        `DCO_IDX_MODE:      rdata_next = mode_next;
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      filt_cfg_reg  <= `DCO_RST_FILT_CFG;
      thr_first_reg <= `DCO_RST_THR_FIRST;
      thr_sec_reg   <= `DCO_RST_THR_SEC;
      pin_cfg_reg   <= `DCO_RST_PIN_CFG;
      preset_reg    <= `DCO_RST_PRESET;
      mode_reg      <= `DCO_RST_MODE;
      wr_pend_reg   <= 1'b0;
      wr_idx_reg    <= 10'h000;
      rdata_reg     <= 32'h00000000;
    end else if (CE) begin
      filt_cfg_reg  <= filt_cfg_next;
      thr_first_reg <= thr_first_next;
      thr_sec_reg   <= thr_sec_next;
      pin_cfg_reg   <= pin_cfg_next;
      preset_reg    <= preset_next;
      mode_reg      <= mode_next;
      wr_pend_reg   <= req & HWRITE & addr_ok;
      if (req) begin
        wr_idx_reg <= idx;
        if (!HWRITE)
          rdata_reg <= {24'h000000, rdata_next};
      end
    end
  end

  assign HRDATA    = rdata_reg;
  assign HREADYOUT = ready_reg;
  assign HRESP     = resp_reg;

  // Zero wait states and OKAY only, yet still flops so that no
  // combinational path runs from the bus inputs to these outputs
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ready_reg <= 1'b1;
      resp_reg  <= 1'b0;
    end else if (CE) begin
      ready_reg <= 1'b1;
      resp_reg  <= 1'b0;
    end
  end

  // Filter choice passes through one more flop on its way to the decimation chain
  always @(posedge SYS_CLK) begin
    if (!RSTN) begin
      wide_reg  <= 1'b0;
      hpass_reg <= 1'b0;
    end else if (CE) begin
      wide_reg  <= filt_cfg_reg[`DCO_BIT_WIDE_BAND];
      hpass_reg <= filt_cfg_reg[`DCO_BIT_HIGHPASS];
    end
  end

  assign QUARTER_DECIM_WIDE_BAND_SEL = wide_reg;
  assign HALF_DECIM_HIGHPASS_SEL     = hpass_reg;

  assign mode    = mode_reg[1:0];
  assign flip_on = (mode == `DCO_MODE_REAL) & filt_cfg_reg[`DCO_BIT_FLIP];
  // Gain only in complex mode; clipping is software's to avoid
  assign gain_on = (mode == `DCO_MODE_COMPLEX) & filt_cfg_reg[`DCO_BIT_GAIN];
  assign take    = SMP_VALID & fifo_rdy;

  // Odd sample index flips on every accepted sample
  always @(posedge SYS_CLK) begin
    if (!RSTN)
      odd_reg <= 1'b0;
    else if (CE & take)
      odd_reg <= ~odd_reg;
  end

  function [11:0] neg_sat;
    input [11:0] s;
    begin
      if (s == `DCO_SMP_MIN)
        neg_sat = `DCO_SMP_MAX;
      else
        neg_sat = ~s + 12'h001;
    end
  endfunction

  // Doubling saturates instead of wrapping
  function [11:0] dbl_sat;
    input [11:0] s;
    begin
      if (s[11] != s[10])
        dbl_sat = s[11] ? `DCO_SMP_MIN : `DCO_SMP_MAX;
      else
        dbl_sat = {s[10:0], 1'b0};
    end
  endfunction

  always @* begin
    out_a = SMP_A;
    out_b = SMP_B;
    if (flip_on & odd_reg) begin
      out_a = neg_sat(SMP_A);
      out_b = neg_sat(SMP_B);
    end else if (gain_on) begin
      out_a = dbl_sat(SMP_A);
      out_b = dbl_sat(SMP_B);
    end
  end

  // Full scale 2048 split in 256 steps of 8
  assign mag_a      = SMP_A[11] ? (~SMP_A + 12'h001) : SMP_A;
  assign mag_b      = SMP_B[11] ? (~SMP_B + 12'h001) : SMP_B;
  assign lvl_first  = {1'b0, thr_first_reg, 3'h0};
  assign lvl_second = {1'b0, thr_sec_reg, 3'h0};
  assign det[0] = (mag_a >= lvl_first);
  assign det[1] = (mag_a >= lvl_second);
  assign det[2] = (mag_b >= lvl_first);
  assign det[3] = (mag_b >= lvl_second);

  // Stream flags ignore the pin enable
  assign fifo_in = {det[1], det[0], out_a, det[3], det[2], out_b};

  dco_fifo #(
    .WIDTH (28),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RSTN),
    .ce        (CE),
    .in_valid  (SMP_VALID),
    .in_ready  (fifo_rdy),
    .in_data   (fifo_in),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );

  assign SMP_READY = fifo_rdy;

  // Compare with >= so a shorter new period ends at once; phase may shift
  assign per_len = `DCO_PERIOD_BASE << pin_cfg_reg[2:0];
  assign per_end = (per_cnt_reg >= per_len - 11'h001);

  // One free-running period shared by all four pins
  always @(posedge SYS_CLK) begin
    if (!RSTN)
      per_cnt_reg <= 11'h000;
    else if (CE) begin
      if (per_end)
        per_cnt_reg <= 11'h000;
      else
        per_cnt_reg <= per_cnt_reg + 11'h001;
    end
  end

  // Only samples actually accepted count as crossings
  assign hit = det & {4{take}};

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      reg  acc_reg;
      reg  pin_reg;
      reg  pin_out_reg;
      wire pin_next;
      // Held through at least one whole period after the crossing
      assign pin_next = hit[i] | (per_end ? acc_reg : pin_reg);
      // Each pin keeps its own flops so no vector has several drivers
      always @(posedge SYS_CLK) begin
        if (!RSTN) begin
          acc_reg     <= 1'b0;
          pin_reg     <= 1'b0;
          pin_out_reg <= 1'b0;
        end else if (CE) begin
          acc_reg     <= per_end ? hit[i] : (acc_reg | hit[i]);
          pin_reg     <= pin_next;
          pin_out_reg <= pin_next & pin_cfg_reg[`DCO_BIT_PIN_EN];
        end
      end
      assign pin_q[i] = pin_out_reg;
    end
  endgenerate

  assign CHAN_A_OVER_FLAG_FIRST  = pin_q[0];
  assign CHAN_A_OVER_FLAG_SECOND = pin_q[1];
  assign CHAN_B_OVER_FLAG_FIRST  = pin_q[2];
  assign CHAN_B_OVER_FLAG_SECOND = pin_q[3];
endmodule // dco_top

// *** dv/dco_host_model.sv ***
// Host-side sink for the output stream, stalling at random or on request
`timescale 1ns/1ps
module dco_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic stall,
  output logic      out_ready
);
  // Random gaps keep the output register under back-pressure
  always @(posedge clk) begin
    out_ready <= rst_n && !stall && ($urandom % 4 != 0);
  end
endmodule // dco_host_model

// *** dv/dco_top_props.sv ***
// Port-level assertions for the filter configuration and overrange block
`timescale 1ns/1ps
module dco_top_props (
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        SMP_READY,
  input wire logic [27:0] OUT_DATA,
  input wire logic        OUT_VALID,
  input wire logic        OUT_READY,
  input wire logic        CHAN_A_OVER_FLAG_FIRST,
  input wire logic        CHAN_A_OVER_FLAG_SECOND,
  input wire logic        CHAN_B_OVER_FLAG_FIRST,
  input wire logic        CHAN_B_OVER_FLAG_SECOND,
  input wire logic        QUARTER_DECIM_WIDE_BAND_SEL,
  input wire logic        HALF_DECIM_HIGHPASS_SEL
);
  wire       take   = CE && HSEL && HTRANS[1] && HREADY;
  wire       cfg_wr = take && HWRITE && HADDR == 32'h00000840;
  wire [3:0] pins   = {CHAN_A_OVER_FLAG_SECOND, CHAN_A_OVER_FLAG_FIRST,
                       CHAN_B_OVER_FLAG_SECOND, CHAN_B_OVER_FLAG_FIRST};
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("slave not ready or not okay");
  AST_RD_UPPER_ZERO: assert property (HRDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RD_STANDS: assert property (!(take && !HWRITE) |=> $stable(HRDATA))
    else $error("read data moved without a read");
  AST_WIDE_SEL_CAUSE: assert property (
    $changed(QUARTER_DECIM_WIDE_BAND_SEL) |-> $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("wide band select moved without a write");
  AST_HP_SEL_CAUSE: assert property (
    $changed(HALF_DECIM_HIGHPASS_SEL) |-> $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("highpass select moved without a write");
  AST_OUT_HOLD: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output word dropped while stalled");
  AST_FULL_HAS_OUT: assert property (!SMP_READY |-> OUT_VALID)
    else $error("input refused with nothing to offer");
  // Holds only while the pin enable stays set during the pulse
  AST_PIN_MIN_LEN: assert property (
    $rose(CHAN_A_OVER_FLAG_FIRST) |-> CHAN_A_OVER_FLAG_FIRST [*8])
    else $error("overrange pulse shorter than one period");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !RSTN |=> pins == 4'h0 && !OUT_VALID && SMP_READY)
    else $error("outputs not quiet in reset");
  cover property ($rose(CHAN_B_OVER_FLAG_FIRST));
  cover property (!SMP_READY);
  cover property (cfg_wr ##3 $changed(HALF_DECIM_HIGHPASS_SEL));
endmodule // dco_top_props
bind dco_top dco_top_props u_props (.*);

// *** dv/tb_downconverter_filter_and_overrange.sv ***
// Self-checking bench for the filter configuration and overrange block
`timescale 1ns/1ps
`include "dco_defines.vh"
module tb_downconverter_filter_and_overrange;
  localparam [7:0] SPIN = 8'h3C; // Arbitrary identification value
  logic        SYS_CLK, RSTN, HWRITE, SMP_VALID, stall, pins_off, ce;
  logic [31:0] HADDR, HWDATA, rd;
  logic [1:0]  HTRANS, mode;
  logic [11:0] SMP_A, SMP_B;
  logic [7:0]  cfg, t1, t2;
  logic [27:0] q [$];
  wire  [31:0] HRDATA;
  wire  [27:0] OUT_DATA;
  wire         HREADYOUT, HRESP, SMP_READY, OUT_VALID, OUT_READY, qw, hh, a0, a1, b0, b1;
  int          miscompares, n_compared, n_acc, i, j, n, c;
  logic [9:0]  ridx [0:7] = '{`DCO_IDX_FILT_CFG, `DCO_IDX_THR_FIRST, `DCO_IDX_THR_SEC,
                             `DCO_IDX_PIN_CFG, `DCO_IDX_PRESET, `DCO_IDX_SPIN,
                             `DCO_IDX_MODE, 10'h300};
  logic [7:0]  rrst [0:7] = '{8'h00, 8'hF2, 8'hAB, 8'h07, 8'h00, SPIN, 8'h00, 8'h00};

  dco_top #(.SILICON_REVISION_ID_VALUE(SPIN)) dut (.SYS_CLK, .RSTN, .CE(ce), .HSEL(1'b1), .HADDR,
    .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT,
    .HRESP, .SMP_A, .SMP_B, .SMP_VALID, .SMP_READY, .OUT_DATA, .OUT_VALID, .OUT_READY,
    .CHAN_A_OVER_FLAG_FIRST(a0), .CHAN_A_OVER_FLAG_SECOND(a1),
    .CHAN_B_OVER_FLAG_FIRST(b0), .CHAN_B_OVER_FLAG_SECOND(b1),
    .QUARTER_DECIM_WIDE_BAND_SEL(qw), .HALF_DECIM_HIGHPASS_SEL(hh));
  dco_host_model host (.clk(SYS_CLK), .rst_n(RSTN), .stall, .out_ready(OUT_READY));

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task chk(input [31:0] s, input [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tmo(input bit bad);
    if (bad) begin
      miscompares++;
      stop_test;
    end
  endtask
  // Address phase, then data phase; each ends where the slave shows ready
  task bus(input logic w, input [9:0] idx, input [7:0] d);
    @(posedge SYS_CLK);
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {20'h00000, idx, 2'h0};
    for (c = 0; c < 2; c++) begin
      n = 0;
      do begin
        @(posedge SYS_CLK);
        n++;
      end while (HREADYOUT !== 1'b1 && n < 50);
      tmo(n >= 50);
      HTRANS <= 2'h0;
      HWDATA <= {24'h000000, d};
    end
    rd = HRDATA;
  endtask
  task rdchk(input [9:0] idx, input [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, e});
  endtask
  function [1:0] fl(input [11:0] s);
    logic [11:0] m;
    m = s[11] ? -s : s;
    fl = {m >= {1'b0, t2, 3'h0}, m >= {1'b0, t1, 3'h0}};
  endfunction
  function [11:0] pr(input [11:0] s);
    if (mode == 2'h1 && cfg[1] && n_acc[0]) pr = (s == 12'h800) ? 12'h7FF : -s;
    else if (mode == 2'h2 && cfg[0]) pr = (s[11] != s[10]) ? {s[11], {11{~s[11]}}} : s << 1;
    else pr = s;
  endfunction
  // Leaves valid up so that calls run back to back
  task send(input [11:0] a, input [11:0] b);
    SMP_A <= a;
    SMP_B <= b;
    SMP_VALID <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (SMP_READY !== 1'b1 && n < 50);
    tmo(n >= 50);
    q.push_back({fl(a), pr(a), fl(b), pr(b)});
    n_acc++;
  endtask
  task drain;
    SMP_VALID <= 1'b0;
    n = 0;
    while (q.size() != 0 && n < 300) begin
      @(posedge SYS_CLK);
      n++;
    end
    tmo(n >= 300);
  endtask

  always @(posedge SYS_CLK) begin
    if (RSTN && OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else chk({4'h0, OUT_DATA}, {4'h0, q.pop_front()});
    end
    if (pins_off) chk({a1, a0, b1, b0}, 4'h0);
  end

  initial begin
    RSTN = 1'b0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    SMP_A = 12'h000;
    SMP_B = 12'h000;
    SMP_VALID = 1'b0;
    stall = 1'b0;
    ce = 1'b1;
    pins_off = 1'b1;
    miscompares = 0;
    n_compared = 0;
    n_acc = 0;
    i = $urandom(35);
    repeat (16) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    for (i = 0; i < 8; i++) rdchk(ridx[i], rrst[i]);
    // The identification value and the unmapped place ignore writes
    for (i = 0; i < 8; i++) begin
      j = $urandom;
      bus(1'b1, ridx[i], j[7:0]);
      rdchk(ridx[i], (i < 5 || i == 6) ? j[7:0] : rrst[i]);
    end
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `DCO_IDX_FILT_CFG, 8'(i << 2));
      repeat (2) @(posedge SYS_CLK);
      chk({qw, hh}, i);
    end
    t1 = 8'h40;
    t2 = 8'h80;
    bus(1'b1, `DCO_IDX_PIN_CFG, 8'h00);
    bus(1'b1, `DCO_IDX_THR_FIRST, t1);
    bus(1'b1, `DCO_IDX_THR_SEC, t2);
    // Saturating cases show the clipping that the extra gain can cause
    for (i = 0; i < 9; i++) begin
      mode = 2'(i / 3);
      cfg = 8'(i % 3 + 1);
      bus(1'b1, `DCO_IDX_MODE, {6'h00, mode});
      bus(1'b1, `DCO_IDX_FILT_CFG, cfg);
      send(12'h800, 12'h7FF);
      send(12'h200, 12'h1FF);
      send(12'h3FF, 12'h400);
      for (j = 0; j < 4; j++) send(12'($urandom), 12'($urandom));
      drain;
    end
    stall <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    for (i = 0; i < 17; i++) send(12'(i), 12'h000);
    SMP_VALID <= 1'b0;
    @(posedge SYS_CLK);
    chk(SMP_READY, 1'b0);
    stall <= 1'b0;
    drain;
    // With the clock enable low an offered sample must not be taken
    ce <= 1'b0;
    SMP_A <= 12'h7FF;
    SMP_VALID <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk({OUT_VALID, SMP_READY}, 2'h1);
    SMP_VALID <= 1'b0;
    ce <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk(OUT_VALID, 1'b0);
    pins_off <= 1'b0;
    // Exponent change mid-run may shift the period phase, hence the slack
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `DCO_IDX_PIN_CFG, 8'(8 + i / 2));
      send(i[0] ? 12'h000 : 12'h801, i[0] ? 12'h801 : 12'h000);
      SMP_VALID <= 1'b0;
      n = 0;
      while ({a1, a0, b1, b0} === 4'h0 && n < 50) begin
        @(posedge SYS_CLK);
        n++;
      end
      tmo(n >= 50);
      chk({a1, a0, b1, b0}, i[0] ? 4'h3 : 4'hC);
      c = 0;
      while ((a0 | b0) === 1'b1 && c < 100) begin
        @(posedge SYS_CLK);
        c++;
      end
      chk(c >= (8 << (i / 2)) && c <= (16 << (i / 2)) + 2, 1);
      drain;
    end
    stop_test;
  end
endmodule // tb_downconverter_filter_and_overrange
